//--- rtl/sriov_function_and_bar_setup.v
// Virtual function numbering, capability fields and VF BAR decode
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sriov_consts.vh"
module sriov_function_and_bar_setup #(
    parameter        NB           = 6,
    // Arbitrary neutral identifier, replace per product
    parameter [15:0] DEF_VF_DEV_ID = 16'h0000
) (
    input  wire        clk_in,
    input  wire        nrst_in,
    input  wire [7:0]  addr_in,
    input  wire [31:0] wr_data_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [31:0] rd_data_out,
    input  wire        req_valid_in,
    input  wire [63:0] req_addr_in,
    input  wire        req_io_in,
    input  wire        req_wr_in,
    input  wire [7:0]  func_in,
    input  wire        intx_req_in,
    output reg         bar_hit_out,
    output reg  [2:0]  bar_hit_index_out,
    output reg         merge_ok_out,
    output reg         func_valid_out,
    output reg         func_is_vf_out,
    output reg         func_owner_out,
    output reg  [2:0]  func_vf_index_out,
    output reg  [7:0]  pf0_first_virtual_function_offset_out,
    output reg  [7:0]  pf1_first_virtual_function_offset_out,
    output reg  [2:0]  primary_function_vf_count_out,
    output reg  [2:0]  secondary_function_vf_count_out,
    output reg         intx_out,
    output reg  [2:0]  intx_pin_out,
    output reg  [2:0]  msi_vectors_out,
    output reg         msi_pvm_out,
    output reg         sriov_cap_pf0_out,
    output reg         sriov_cap_pf1_out,
    output reg         flr_supported_out
);
    reg  [12:0] ctrl;
    reg  [2:0]  n0;
    reg  [2:0]  n1;
    reg  [15:0] pf0_did;
    reg  [15:0] pf1_did;
    reg  [3:0]  pf0_ver;
    reg  [3:0]  pf1_ver;
    reg  [31:0] pf0_page;
    reg  [31:0] pf1_page;
    reg  [9:0]  bar_cfg  [0:NB-1];
    reg  [31:0] bar_base [0:NB-1];

    wire        sriov_en = ctrl[`C_SRIOV];
    wire        pf1_en   = ctrl[`C_PF1];
    wire        legacy   = ctrl[`C_LEGACY];
    wire        root     = ctrl[`C_ROOT];
    wire [2:0]  pin      = ctrl[`C_PIN_HI:`C_PIN_LO];
    // Second function owns no VF while it is absent
    wire [2:0]  n1_eff   = pf1_en ? n1 : 3'd0;

    // Count clamp for writes to the VF count register
    wire [2:0]  w0 = wr_data_in[`N0_HI:`N0_LO];
    wire [2:0]  w1 = wr_data_in[`N1_HI:`N1_LO];
    wire [2:0]  c0 = (w0 > `VF_SLOTS) ? `VF_SLOTS : w0;
    wire [2:0]  room = `VF_SLOTS - c0;
    wire [2:0]  c1 = (w1 > room) ? room : w1;

    wire        wr_cfg   = wr_in & (addr_in[7:5] == `BAR_CFG_PAGE);
    wire        wr_base  = wr_in & (addr_in[7:5] == `BAR_BASE_PAGE);
    wire [2:0]  slot     = addr_in[4:2];

    // Effective BAR settings
    wire [NB:0]   wide_ext;
    wire [NB-1:0] eff_pf;
    wire [NB-1:0] hit;
    wire [9:0]    eff_cfg [0:NB-1];

    assign wide_ext[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < NB; i = i + 1) begin : g_bar
            wire        c_en   = bar_cfg[i][`B_EN];
            wire        c_io   = bar_cfg[i][`B_IO];
            wire        c_64   = bar_cfg[i][`B_64];
            wire        c_pf   = bar_cfg[i][`B_PF];
            wire [5:0]  c_sz   = bar_cfg[i][`B_SZ_HI:`B_SZ_LO];
            wire        used   = wide_ext[i];
            wire        slot_ok = !root || (i < `ROOT_BARS);
            wire        io_ok  = !c_io || (legacy && !c_64);
            wire        w_ok   = !c_64 || (!c_io && (i < `LAST_BAR));
            // Standard endpoint refuses 32-bit prefetchable below BAR5
            wire        pf_ok  = legacy || c_io || !c_pf || c_64 ||
                                 (i == `LAST_BAR);
            wire        en     = c_en && !used && slot_ok && io_ok &&
                                 w_ok && pf_ok;
            wire        wide   = en && c_64;
            wire [5:0]  sz_min = (c_io || legacy) ? `SZ_MIN_LEG
                                                  : `SZ_MIN_STD;
            wire [5:0]  sz_max = wide ? `SZ_MAX_64 : `SZ_MAX_32;
            wire [5:0]  sz     = (c_sz < sz_min) ? sz_min :
                                 (c_sz > sz_max) ? sz_max : c_sz;
            wire [31:0] hi;
            if (i < NB - 1) begin : g_hi
                assign hi = wide ? bar_base[i+1] : 32'h0;
            end else begin : g_nohi
                assign hi = 32'h0;
            end
            assign wide_ext[i+1] = wide;
            assign eff_pf[i]     = en && c_pf && !c_io;
            assign eff_cfg[i]    = en ? {sz, eff_pf[i], wide, c_io, 1'b1}
                                      : 10'h000;
            bar_window_match u_match (
                .en_in     (en),
                .io_in     (c_io),
                .wide_in   (wide),
                .size_in   (sz),
                .base_in   ({hi, bar_base[i]}),
                .addr_in   (req_addr_in),
                .req_io_in (req_io_in),
                .hit_out   (hit[i])
            );
        end
    endgenerate

    // Lowest numbered BAR wins an overlap
    reg        next_hit;
    reg [2:0]  next_idx;
    integer    k;
    always @* begin
        next_hit = 1'b0;
        next_idx = 3'd0;
        for (k = NB - 1; k >= 0; k = k - 1) begin
            if (hit[k]) begin
                next_hit = 1'b1;
                next_idx = k[2:0];
            end
        end
    end

    // Function number to owner and VF index
    wire [7:0] vf_rel   = func_in - `VF_FIRST_FN;
    wire [7:0] n0_w     = {5'h00, n0};
    wire [7:0] n_all    = {5'h00, n0} + {5'h00, n1_eff};
    wire       is_vf    = sriov_en && (func_in >= `VF_FIRST_FN) &&
                          (vf_rel < n_all);
    wire       in_pf1   = vf_rel >= n0_w;
    wire [7:0] vf_local = in_pf1 ? (vf_rel - n0_w) : vf_rel;
    wire       is_pf0   = (func_in == `PF0_FN);
    wire       is_pf1   = pf1_en && (func_in == `PF1_FN);

    // Offsets are first VF number minus own number
    wire [7:0] ofs0 = (n0 != 3'd0) ? (`VF_FIRST_FN - `PF0_FN)
                                   : 8'h00;
    wire [7:0] ofs1 = pf1_en ? (`PF1_OFS_BASE + n0_w) : 8'h00;

    wire       cap0 = sriov_en;
    wire       cap1 = sriov_en && pf1_en;
    wire       flr  = ctrl[`C_FLR] && !root;

    // Register read mux
    reg [31:0] next_rd;
    always @* begin
        next_rd = 32'h0;
        case (addr_in)
            `REG_CTRL: begin
                next_rd = {19'h0, ctrl};
            end
            `REG_VFCNT: begin
                next_rd = {25'h0, n1, 1'b0, n0};
            end
            `REG_PF0_ID: begin
                next_rd = {12'h0, pf0_ver, pf0_did};
            end
            `REG_PF1_ID: begin
                next_rd = {12'h0, pf1_ver, pf1_did};
            end
            `REG_PF0_PAGE: begin
                next_rd = pf0_page;
            end
            `REG_PF1_PAGE: begin
                next_rd = pf1_page;
            end
            `REG_STATUS: begin
                next_rd = {13'h0, flr, cap1, cap0, ofs1, ofs0};
            end
            default: begin
                if (addr_in[7:5] == `BAR_CFG_PAGE && slot < NB) begin
                    next_rd = {22'h0, eff_cfg[slot]};
                end else if (addr_in[7:5] == `BAR_BASE_PAGE &&
                             slot < NB) begin
                    next_rd = bar_base[slot];
                end else begin
                    next_rd = 32'h0;
                end
            end
        endcase
    end

    // Register writes
    integer j;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl     <= `CTRL_RST;
            n0       <= 3'd0;
            n1       <= 3'd0;
            pf0_did  <= DEF_VF_DEV_ID;
            pf1_did  <= DEF_VF_DEV_ID;
            pf0_ver  <= `VER_RST;
            pf1_ver  <= `VER_RST;
            pf0_page <= `PAGE_RST;
            pf1_page <= `PAGE_RST;
            for (j = 0; j < NB; j = j + 1) begin
                bar_cfg[j]  <= 10'h000;
                bar_base[j] <= 32'h0;
            end
        end else if (wr_in) begin
            case (addr_in)
                `REG_CTRL: begin
                    ctrl <= wr_data_in[12:0];
                end
                `REG_VFCNT: begin
                    n0 <= c0;
                    n1 <= c1;
                end
                `REG_PF0_ID: begin
                    pf0_did <= wr_data_in[`DID_HI:0];
                    pf0_ver <= wr_data_in[`VER_HI:`VER_LO];
                end
                `REG_PF1_ID: begin
                    pf1_did <= wr_data_in[`DID_HI:0];
                    pf1_ver <= wr_data_in[`VER_HI:`VER_LO];
                end
                `REG_PF0_PAGE: begin
                    pf0_page <= wr_data_in;
                end
                `REG_PF1_PAGE: begin
                    pf1_page <= wr_data_in;
                end
                default: begin
                    if (wr_cfg && slot < NB) begin
                        bar_cfg[slot] <= wr_data_in[9:0];
                    end
                    if (wr_base && slot < NB) begin
                        bar_base[slot] <= wr_data_in;
                    end
                end
            endcase
        end
    end

    // Registered outputs
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out                           <= 32'h0;
            bar_hit_out                           <= 1'b0;
            bar_hit_index_out                     <= 3'd0;
            merge_ok_out                          <= 1'b0;
            func_valid_out                        <= 1'b0;
            func_is_vf_out                        <= 1'b0;
            func_owner_out                        <= 1'b0;
            func_vf_index_out                     <= 3'd0;
            pf0_first_virtual_function_offset_out <= 8'h00;
            pf1_first_virtual_function_offset_out <= 8'h00;
            primary_function_vf_count_out         <= 3'd0;
            secondary_function_vf_count_out       <= 3'd0;
            intx_out                              <= 1'b0;
            intx_pin_out                          <= `PIN_NONE;
            msi_vectors_out                       <= 3'd0;
            msi_pvm_out                           <= 1'b0;
            sriov_cap_pf0_out                     <= 1'b0;
            sriov_cap_pf1_out                     <= 1'b0;
            flr_supported_out                     <= 1'b0;
        end else begin
            rd_data_out <= rd_in ? next_rd : 32'h0;
            bar_hit_out       <= req_valid_in && next_hit;
            bar_hit_index_out <= next_idx;
            // Merging is only safe where reads have no side effects
            merge_ok_out <= req_valid_in && next_hit && req_wr_in &&
                            eff_pf[next_idx];
            func_valid_out    <= is_vf || is_pf0 || is_pf1;
            func_is_vf_out    <= is_vf;
            func_owner_out    <= is_vf ? in_pf1 : is_pf1;
            func_vf_index_out <= is_vf ? vf_local[2:0] : 3'd0;
            pf0_first_virtual_function_offset_out <= ofs0;
            pf1_first_virtual_function_offset_out <= ofs1;
            primary_function_vf_count_out   <= n0;
            secondary_function_vf_count_out <= n1_eff;
            intx_out <= intx_req_in && ctrl[`C_INTX] &&
                        (pin != `PIN_NONE);
            intx_pin_out <= ctrl[`C_INTX] ? pin : `PIN_NONE;
            msi_vectors_out   <= ctrl[`C_MSI_HI:`C_MSI_LO];
            msi_pvm_out       <= ctrl[`C_PVM];
            sriov_cap_pf0_out <= cap0;
            sriov_cap_pf1_out <= cap1;
            flr_supported_out <= flr;
        end
    end
endmodule // sriov_function_and_bar_setup
`default_nettype wire

//--- rtl/sriov_consts.vh
// Constants for the virtual function and BAR setup block
// Functional notes
// - Virtual functions occupy function numbers 64 to 69, six slots.
// - First physical function is number 0, second is number 1.
// - Virtual functions numbered consecutively, first function's ones first.
// - First-VF offset is first VF number minus own function number.
// - First function's offset is 64 whenever it owns any VF.
// - Second function's offset is 63 plus first function's VF count.
// - Total VF count of both functions is capped at six.
// - Each physical function has a four-bit capability version.
// - Each physical function holds one 16-bit VF device identifier.
// - Page size bitmap 32 bits; bit n means 2^(n+12) bytes.
// - A 64-bit BAR takes the next BAR as upper half.
// - I/O BARs are 32-bit, never prefetchable, legacy endpoint only. Code also enables them on a root port when the legacy bit is set.
// - A BAR claims only requests of its own space type.
// - Endpoint has six BAR slots, root port only two.
// - Minimum aperture 128 bytes standard, 16 bytes legacy.
// - Maximum aperture 2 GB for 32-bit, 256 GB for 64-bit.
// - Standard endpoint prefetchable BARs except BAR5 must be 64-bit.
// - Enabled INTx signals on chosen pin; pin none disables it.
// - MSI advertises vector count and optional per-vector masking.
// - Virtualization capability present in both functions when second exists.
// - Function reset supported only as endpoint, never root port.
`ifndef SRIOV_CONSTS_VH
`define SRIOV_CONSTS_VH

`define REG_CTRL        8'h00
`define REG_VFCNT       8'h04
`define REG_PF0_ID      8'h08
`define REG_PF1_ID      8'h0c
`define REG_PF0_PAGE    8'h10
`define REG_PF1_PAGE    8'h14
`define REG_STATUS      8'h18
`define BAR_CFG_PAGE    3'b001
`define BAR_BASE_PAGE   3'b010

`define C_SRIOV         0
`define C_PF1           1
`define C_LEGACY        2
`define C_ROOT          3
`define C_INTX          4
`define C_PIN_LO        5
`define C_PIN_HI        7
`define C_FLR           8
`define C_MSI_LO        9
`define C_MSI_HI        11
`define C_PVM           12
`define CTRL_RST        13'h0003

`define N0_LO           0
`define N0_HI           2
`define N1_LO           4
`define N1_HI           6
`define DID_HI          15
`define VER_LO          16
`define VER_HI          19
`define VER_RST         4'h1
`define PAGE_RST        32'h00000001

`define ST_OFS1_LO      8
`define ST_CAP0         16
`define ST_CAP1         17
`define ST_FLR          18

`define B_EN            0
`define B_IO            1
`define B_64            2
`define B_PF            3
`define B_SZ_LO         4
`define B_SZ_HI         9

`define VF_FIRST_FN     8'd64
`define VF_SLOTS        3'd6
`define PF1_OFS_BASE    8'd63
`define PF0_FN          8'd0
`define PF1_FN          8'd1
`define PIN_NONE        3'd0
`define SZ_MIN_STD      6'd7
`define SZ_MIN_LEG      6'd4
`define SZ_MAX_32       6'd31
`define SZ_MAX_64       6'd38
`define ROOT_BARS       2
`define LAST_BAR        5

`endif

//--- rtl/bar_window_match.v
// Address match of one BAR aperture
`timescale 1ns/1ps
`default_nettype none
module bar_window_match (
    input  wire        en_in,
    input  wire        io_in,
    input  wire        wide_in,
    input  wire [5:0]  size_in,
    input  wire [63:0] base_in,
    input  wire [63:0] addr_in,
    input  wire        req_io_in,
    output wire        hit_out
);
    wire [63:0] mask;
    wire        same_space;
    wire        in_window;
    wire        low_only;

    // Aperture is a power of two, so the base is aligned to it
    assign mask       = ~((64'h1 << size_in) - 64'h1);
    assign same_space = (io_in == req_io_in);
    assign in_window  = (((addr_in ^ base_in) & mask) == 64'h0);
    // A 32-bit BAR cannot see addresses above 4 GB
    assign low_only   = wide_in | (addr_in[63:32] == 32'h0);
    assign hit_out    = en_in & same_space & in_window & low_only;
endmodule // bar_window_match
`default_nettype wire

//--- tb/sriov_setup_assertions.sv
// Concurrent checks on VF numbering, BAR decode and INTx outputs
`timescale 1ns/1ps
`default_nettype none
module sriov_setup_checker #(
    parameter NB = 6
) (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       req_valid_in,
    input wire logic       bar_hit_out,
    input wire logic [2:0] bar_hit_index_out,
    input wire logic [7:0] func_in,
    input wire logic       func_valid_out,
    input wire logic       func_is_vf_out,
    input wire logic       func_owner_out,
    input wire logic [2:0] func_vf_index_out,
    input wire logic [7:0] pf0_first_virtual_function_offset_out,
    input wire logic [7:0] pf1_first_virtual_function_offset_out,
    input wire logic [2:0] primary_function_vf_count_out,
    input wire logic [2:0] secondary_function_vf_count_out,
    input wire logic       intx_req_in,
    input wire logic       intx_out,
    input wire logic [2:0] intx_pin_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence no_request;
        !req_valid_in;
    endsequence
    sequence first_vf_lookup;
        func_in == 8'd64 && primary_function_vf_count_out != 3'd0;
    endsequence
    hit_needs_request_a: assert property (no_request |=> !bar_hit_out)
        else $error("BAR hit without a request");
    hit_index_range_a: assert property (bar_hit_out |-> bar_hit_index_out < NB)
        else $error("BAR hit index beyond slot count");
    pf0_offset_value_a: assert property (primary_function_vf_count_out != 3'd0
        |-> pf0_first_virtual_function_offset_out == 8'd64)
        else $error("first function offset not 64");
    pf1_offset_value_a: assert property (secondary_function_vf_count_out != 3'd0
        |-> pf1_first_virtual_function_offset_out
            == 8'd63 + {5'd0, primary_function_vf_count_out})
        else $error("second function offset wrong");
    vf_total_cap_a: assert property ({1'b0, primary_function_vf_count_out}
        + {1'b0, secondary_function_vf_count_out} <= 4'd6)
        else $error("VF total above six");
    first_vf_owner_a: assert property (first_vf_lookup |=> func_is_vf_out
        && !func_owner_out && func_vf_index_out == 3'd0)
        else $error("function 64 not first VF of first function");
    pf0_number_a: assert property (func_in == 8'd0 |=> func_valid_out
        && !func_is_vf_out && !func_owner_out)
        else $error("function 0 not first physical function");
    vf_range_top_a: assert property (func_in > 8'd69 |=> !func_valid_out)
        else $error("function above 69 reported valid");
    intx_pin_cause_a: assert property (intx_out
        |-> intx_pin_out != 3'd0 && $past(intx_req_in))
        else $error("INTx raised without pin or request");
endmodule // sriov_setup_checker
bind sriov_function_and_bar_setup sriov_setup_checker #(.NB(NB))
    i_sriov_setup_checker (.*);
`default_nettype wire

//--- tb/root_request_model.sv
// Root complex side: issues one memory or I/O request per go pulse
`timescale 1ns/1ps
`default_nettype none
module root_request_model (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        go_in,
    input  wire logic [63:0] addr_in,
    input  wire logic        io_in,
    input  wire logic        wr_in,
    output var  logic        req_valid_out,
    output var  logic [63:0] req_addr_out,
    output var  logic        req_io_out,
    output var  logic        req_wr_out
);
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_valid_out <= 1'b0;
            req_addr_out <= 64'h0;
            req_io_out <= 1'b0;
            req_wr_out <= 1'b0;
        end else if (go_in) begin
            req_valid_out <= 1'b1;
            req_addr_out <= addr_in;
            req_io_out <= io_in;
            // Byte writes arrive already merged into one word
            req_wr_out <= wr_in;
        end else begin
            // Released lines toggle so stale values cannot fake a hit
            req_valid_out <= 1'b0;
            req_addr_out <= ~req_addr_out;
            req_io_out <= ~req_io_out;
            req_wr_out <= ~req_wr_out;
        end
    end
endmodule // root_request_model
`default_nettype wire

//--- tb/sriov_function_and_bar_setup_bench.sv
// Register, lookup and BAR decode tests of the SR-IOV setup block
`timescale 1ns/1ps
`default_nettype none
module sriov_function_and_bar_setup_bench;
    logic        clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0]  addr_in = 8'h0, func_in = 8'h02;
    logic [31:0] wr_data_in = 32'h0, rd_data_out, rdat;
    logic        req_valid_in, req_io_in, req_wr_in, intx_req_in = 1'b0;
    logic        go = 1'b0, go_io = 1'b0, go_wr = 1'b0;
    logic [63:0] req_addr_in, go_addr = 64'h0;
    logic        bar_hit_out, merge_ok_out, func_valid_out, func_is_vf_out;
    logic        func_owner_out, intx_out, msi_pvm_out, sriov_cap_pf0_out;
    logic        sriov_cap_pf1_out, flr_supported_out;
    logic [2:0]  bar_hit_index_out, func_vf_index_out, intx_pin_out;
    logic [2:0]  msi_vectors_out, primary_function_vf_count_out;
    logic [2:0]  secondary_function_vf_count_out;
    logic [7:0]  pf0_first_virtual_function_offset_out;
    logic [7:0]  pf1_first_virtual_function_offset_out;
    logic [5:0]  vf_map [6] = '{6'h30, 6'h31, 6'h38, 6'h39, 6'h3a, 6'h00};
    int          num_errors = 0, cmp_count = 0;

    sriov_function_and_bar_setup i_sriov_function_and_bar_setup (.*);
    root_request_model i_root_request_model (.clk_in(clk_in),
        .nrst_in(nrst_in), .go_in(go), .addr_in(go_addr), .io_in(go_io),
        .wr_in(go_wr), .req_valid_out(req_valid_in),
        .req_addr_out(req_addr_in), .req_io_out(req_io_in),
        .req_wr_out(req_wr_in));

    always #2.5 clk_in = ~clk_in;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk($sformatf("reg %h", a), rd_data_out, e);
    endtask
    // Derived outputs follow the register update by one edge
    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic req(input logic [63:0] a, input logic io, w,
                       input logic [4:0] e);
        @(posedge clk_in);
        go_addr <= a;
        go_io <= io;
        go_wr <= w;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        #1 chk($sformatf("hit %h", a),
            {bar_hit_out, bar_hit_index_out, merge_ok_out}, e);
    endtask
    task automatic fn(input logic [7:0] f, input logic [5:0] e);
        @(posedge clk_in);
        func_in <= f;
        @(posedge clk_in);
        #1 chk($sformatf("func %0d", f), {func_valid_out, func_is_vf_out,
            func_owner_out, func_vf_index_out}, e);
    endtask
    task automatic ofs(input logic [31:0] e);
        settle();
        chk("offsets", {pf0_first_virtual_function_offset_out,
            pf1_first_virtual_function_offset_out,
            5'd0, primary_function_vf_count_out,
            5'd0, secondary_function_vf_count_out}, e);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        rc(8'h18, 32'h00033f00);
        rc(8'h08, 32'h00010000);
        wr(8'h0c, 32'hfff2beef);
        rc(8'h0c, 32'h0002beef);
        wr(8'h14, 32'h80000003);
        rc(8'h14, 32'h80000003);
        wr(8'h1c, 32'hffffffff);
        rc(8'h1c, 32'h0);
        wr(8'h04, 32'h32);
        ofs(32'h40410203);
        fn(8'd0, 6'h20);
        fn(8'd1, 6'h28);
        for (int i = 0; i < 6; i++)
            fn(8'd64 + 8'(i), vf_map[i]);
        wr(8'h04, 32'h77);
        rc(8'h04, 32'h06);
        ofs(32'h40450600);
        wr(8'h04, 32'h0);
        ofs(32'h003f0000);
        wr(8'h20, 32'h0c1);
        wr(8'h40, 32'h10000000);
        req(64'h10000010, 1'b0, 1'b0, 5'h10);
        req(64'h10000010, 1'b1, 1'b0, 5'h00);
        req(64'h10001000, 1'b0, 1'b0, 5'h00);
        wr(8'h28, 32'h14d);
        wr(8'h48, 32'h00100000);
        wr(8'h4c, 32'h2);
        rc(8'h2c, 32'h0);
        req(64'h200100040, 1'b0, 1'b1, 5'h15);
        req(64'h000100040, 1'b0, 1'b0, 5'h00);
        wr(8'h24, 32'h0c9);
        rc(8'h24, 32'h0);
        wr(8'h34, 32'h0c9);
        rc(8'h34, 32'h0c9);
        wr(8'h30, 32'h0c3);
        rc(8'h30, 32'h0);
        wr(8'h20, 32'h281);
        rc(8'h20, 32'h1f1);
        wr(8'h28, 32'h3fd);
        rc(8'h28, 32'h26d);
        wr(8'h20, 32'h021);
        rc(8'h20, 32'h071);
        wr(8'h00, 32'h0007);
        rc(8'h20, 32'h041);
        rc(8'h30, 32'h0c3);
        wr(8'h50, 32'h00001000);
        req(64'h1010, 1'b1, 1'b0, 5'h18);
        wr(8'h00, 32'h010b);
        rc(8'h28, 32'h0);
        rc(8'h18, 32'h00033f00);
        wr(8'h00, 32'h0103);
        rc(8'h18, 32'h00073f00);
        wr(8'h00, 32'h0033);
        intx_req_in <= 1'b1;
        settle();
        chk("intx", {intx_out, intx_pin_out}, 32'h9);
        wr(8'h00, 32'h0013);
        settle();
        chk("intx", {intx_out, intx_pin_out}, 32'h0);
        wr(8'h00, 32'h1a03);
        settle();
        chk("msi", {msi_pvm_out, msi_vectors_out}, 32'hd);
        wr(8'h00, 32'h0001);
        settle();
        chk("cap", {sriov_cap_pf0_out, sriov_cap_pf1_out}, 32'h2);
        end_sim();
    end
endmodule // sriov_function_and_bar_setup_bench
`default_nettype wire
